// *** design/mdc_dma.sv ***
// mdc_dma: eight channel dma engine with per-channel FIFOs, chaining and register port
// assumes a bus slave that holds mem_ack for one cycle per access and synchronous peripheral requests
`timescale 1ns/10ps
module mdc_dma (
	input  wire logic               mclk,
	input  wire logic               rst_b,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [31:0]             reg_rdata,
	output mdc_pkg::mdc_bus_t       mem_cmd,
	input  wire logic [63:0]        mem_rdata,
	input  wire logic               mem_ack,
	input  wire logic [15:0]        per_req,
	input  wire logic [15:0]        per_single,
	input  wire logic [15:0]        per_last,
	output logic [15:0]             per_ack,
	output logic                    irq
);
	logic [31:0]          sar [mdc_pkg::NCH];
	logic [31:0]          dar [mdc_pkg::NCH];
	logic [31:0]          sar0 [mdc_pkg::NCH];
	logic [31:0]          dar0 [mdc_pkg::NCH];
	logic [29:0]          chain_pointer [mdc_pkg::NCH];
	mdc_pkg::mdc_ctl_t    channel_control_reg [mdc_pkg::NCH];
	mdc_pkg::mdc_ctl_t    ctl0 [mdc_pkg::NCH];
	mdc_pkg::mdc_cfg_t    cfg [mdc_pkg::NCH];
	mdc_pkg::mdc_sg_t     sgr [mdc_pkg::NCH];
	mdc_pkg::mdc_sg_t     dsr [mdc_pkg::NCH];
	logic [63:0]          fifo_mem [mdc_pkg::NCH][mdc_pkg::FDEPTH];
	logic [1:0]           wp [mdc_pkg::NCH];
	logic [1:0]           rp [mdc_pkg::NCH];
	logic [2:0]           fcnt [mdc_pkg::NCH];
	logic [7:0]           ch_en;
	logic [23:0]          sw_src;
	logic [23:0]          sw_dst;
	logic [7:0]           tfr_flag;
	logic [7:0]           blk_flag;
	mdc_pkg::mdc_state_t  st;
	logic [2:0]           act;
	logic [1:0]           ccnt;
	logic [11:0]          scnt;
	logic [11:0]          dcnt;
	logic [11:0]          sgc;
	logic [11:0]          dgc;
	logic [7:0]           scred;
	logic [7:0]           dcred;
	logic                 last_seen;
	logic [1:0]           sgap;
	logic [1:0]           dgap;
	mdc_pkg::mdc_ctl_t    cc;
	mdc_pkg::mdc_cfg_t    cf;
	logic [2:0]           cnt;
	logic [2:0]           pick;
	logic [31:0]          cur_sar;
	logic                 pflow;
	logic                 src_fin;
	logic                 blk_end;
	logic                 room;
	logic                 avail;
	logic                 no_pref;
	logic                 do_rd;
	logic                 do_wr;
	logic                 rd_done;
	logic                 wr_done;
	logic                 fetch_ack;
	logic                 sbnd;
	logic                 dbnd;
	logic                 swb;
	logic                 sws;
	logic                 dwb;
	logic                 dws;
	logic                 s_take;
	logic                 d_take;
	logic                 s_one;
	logic                 d_one;
	logic                 chained;
	logic                 multi;
	logic                 fin;
	logic [23:0]          s_clr;
	logic [23:0]          d_clr;

	// item step, plus the boundary step at a gather or scatter edge
	function automatic logic [31:0] adv(input logic [31:0] a, input logic [1:0] m, input logic [1:0] w,
		input logic b, input logic [19:0] x);
		logic [31:0] d;
		d = 32'h1 << w;
		if (b) begin
			d = d + {12'h0, x};
		end
		if (m == mdc_pkg::STEP_INC) begin
			return a + d;
		end else if (m == mdc_pkg::STEP_DEC) begin
			return a - d;
		end
		return a;
	endfunction

	// lowest numbered enabled channel wins the engine for a whole block
	always_comb begin
		pick = 3'h0;
		for (int i = mdc_pkg::NCH - 1; i >= 0; i--) begin
			if (ch_en[i]) begin
				pick = 3'(i);
			end
		end
	end

	always_comb begin
		cc = channel_control_reg[act];
		cf = cfg[act];
		cnt = fcnt[act];
		cur_sar = sar[act];
		pflow = cf.pflow & (cc.sper | cc.dper);
		swb = sw_src[{2'h0, act}];
		sws = sw_src[{2'h1, act}];
		dwb = sw_dst[{2'h0, act}];
		dws = sw_dst[{2'h1, act}];
		// peripheral flow: the last transaction flagged by the peripheral ends the block
		src_fin = pflow ? (cc.sper & last_seen & scred == 8'h0) : (scnt == cc.blk);
		if (pflow) begin
			blk_end = last_seen & (cc.sper ? (scred == 8'h0 & cnt == 3'h0) : dcred == 8'h0);
		end else begin
			blk_end = dcnt == cc.blk;
		end
		room = cf.fifo_mode ? cnt < mdc_pkg::FHALF : cnt < mdc_pkg::FFULL;
		// the tail of a block drains below half full so fifo mode cannot stall
		avail = (cf.fifo_mode & ~src_fin) ? cnt >= mdc_pkg::FHALF : cnt != 3'h0;
		no_pref = pflow & cc.dper & ~cc.sper & cf.flow_prefetch_mode & dcred == 8'h0;
		// memory sides need no credit, peripheral sides need a taken request
		do_wr = st == mdc_pkg::ST_RUN & ~blk_end & (~cc.dper | dcred != 8'h0) & avail;
		do_rd = st == mdc_pkg::ST_RUN & ~blk_end & ~do_wr & (~cc.sper | scred != 8'h0) & room
			& ~src_fin & ~no_pref;
		rd_done = st == mdc_pkg::ST_RD & mem_ack;
		wr_done = st == mdc_pkg::ST_WR & mem_ack;
		fetch_ack = st == mdc_pkg::ST_FETCH & mem_cmd.req & mem_ack;
		sbnd = sgr[act].cnt != 12'h0 & sgc == sgr[act].cnt - 12'h1;
		dbnd = dsr[act].cnt != 12'h0 & dgc == dsr[act].cnt - 12'h1;
		// a software-requested side never looks at the request pins
		s_take = st == mdc_pkg::ST_RUN & cc.sper & scred == 8'h0 & sgap == 2'h0 & ~last_seen
			& (cf.ssw ? (swb | sws) : (per_req[cf.sif] | per_single[cf.sif]));
		d_take = st == mdc_pkg::ST_RUN & cc.dper & dcred == 8'h0 & dgap == 2'h0 & ~last_seen
			& (cf.dsw ? (dwb | dws) : (per_req[cf.dif] | per_single[cf.dif]));
		s_one = cf.ssw ? ~swb : ~per_req[cf.sif];
		d_one = cf.dsw ? ~dwb : ~per_req[cf.dif];
		s_clr = (s_take & cf.ssw) ? (mdc_pkg::SW_CLR << act) : 24'h0;
		d_clr = (d_take & cf.dsw) ? (mdc_pkg::SW_CLR << act) : 24'h0;
		chained = cc.smb == mdc_pkg::MB_CHAIN | cc.dmb == mdc_pkg::MB_CHAIN;
		multi = cc.smb != 2'h0 | cc.dmb != 2'h0;
		fin = st == mdc_pkg::ST_BEND & (chained ? chain_pointer[act] == 30'h0 : ~(multi & ch_en[act]));
	end

	// engine sequencing and bus master; all on mclk
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= mdc_pkg::ST_IDLE;
			act <= 3'h0;
			ccnt <= 2'h0;
			mem_cmd <= '0;
		end else begin
			unique case (st)
				mdc_pkg::ST_IDLE: begin
					ccnt <= 2'h0;
					if (ch_en != 8'h0) begin
						act <= pick;
						if (channel_control_reg[pick].smb == mdc_pkg::MB_CHAIN
							| channel_control_reg[pick].dmb == mdc_pkg::MB_CHAIN) begin
							st <= mdc_pkg::ST_FETCH;
						end else begin
							st <= mdc_pkg::ST_RUN;
						end
					end
				end
				mdc_pkg::ST_FETCH: begin
					if (!mem_cmd.req) begin
						// chain items sit on word boundaries
						mem_cmd.req <= 1'b1;
						mem_cmd.we <= 1'b0;
						mem_cmd.size <= mdc_pkg::WORD_SIZE;
						mem_cmd.addr <= {chain_pointer[act], 2'h0} + {28'h0, ccnt, 2'h0};
					end else if (mem_ack) begin
						mem_cmd.req <= 1'b0;
						ccnt <= ccnt + 2'h1;
						if (ccnt == mdc_pkg::CHAIN_LAST) begin
							st <= mdc_pkg::ST_RUN;
						end
					end
				end
				mdc_pkg::ST_RUN: begin
					if (blk_end) begin
						st <= mdc_pkg::ST_BEND;
					end else if (do_wr) begin
						mem_cmd.req <= 1'b1;
						mem_cmd.we <= 1'b1;
						mem_cmd.size <= cc.dest_item_width;
						mem_cmd.addr <= dar[act];
						mem_cmd.wdata <= fifo_mem[act][rp[act]];
						st <= mdc_pkg::ST_WR;
					end else if (do_rd) begin
						mem_cmd.req <= 1'b1;
						mem_cmd.we <= 1'b0;
						mem_cmd.size <= cc.source_item_width;
						mem_cmd.addr <= sar[act];
						st <= mdc_pkg::ST_RD;
					end
				end
				mdc_pkg::ST_RD, mdc_pkg::ST_WR: begin
					if (mem_ack) begin
						mem_cmd.req <= 1'b0;
						st <= mdc_pkg::ST_RUN;
					end
				end
				mdc_pkg::ST_BEND: begin
					ccnt <= 2'h0;
					if (fin) begin
						st <= mdc_pkg::ST_IDLE;
					end else if (chained) begin
						st <= mdc_pkg::ST_FETCH;
					end else begin
						st <= mdc_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	// transaction credits, item counts and boundary counters of the active block
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{scnt, dcnt, sgc, dgc, scred, dcred, last_seen, sgap, dgap, per_ack} <= '0;
		end else if (st == mdc_pkg::ST_IDLE || st == mdc_pkg::ST_BEND) begin
			{scnt, dcnt, sgc, dgc, scred, dcred, last_seen, sgap, dgap, per_ack} <= '0;
		end else begin
			per_ack <= 16'h0;
			sgap <= (sgap != 2'h0) ? sgap - 2'h1 : 2'h0;
			dgap <= (dgap != 2'h0) ? dgap - 2'h1 : 2'h0;
			// a burst grants two to the power of the programmed length, a single grants one item
			if (s_take) begin
				scred <= s_one ? 8'h1 : 8'h1 << cc.source_burst_length;
			end
			if (d_take) begin
				dcred <= d_one ? 8'h1 : 8'h1 << cc.dest_burst_length;
			end
			if (pflow & cc.sper & s_take) begin
				last_seen <= cf.ssw ? sw_src[{2'h2, act}] : per_last[cf.sif];
			end
			if (pflow & ~cc.sper & d_take) begin
				last_seen <= cf.dsw ? sw_dst[{2'h2, act}] : per_last[cf.dif];
			end
			if (rd_done) begin
				scnt <= scnt + 12'h1;
				sgc <= sbnd ? 12'h0 : sgc + 12'h1;
				if (cc.sper) begin
					scred <= scred - 8'h1;
					if (scred == 8'h1) begin
						sgap <= mdc_pkg::REQ_GAP;
						per_ack[cf.sif] <= ~cf.ssw;
					end
				end
			end
			if (wr_done) begin
				dcnt <= dcnt + 12'h1;
				dgc <= dbnd ? 12'h0 : dgc + 12'h1;
				if (cc.dper) begin
					dcred <= dcred - 8'h1;
					if (dcred == 8'h1) begin
						dgap <= mdc_pkg::REQ_GAP;
						per_ack[cf.dif] <= ~cf.dsw;
					end
				end
			end
		end
	end

	// per-channel FIFO pointers; leftovers of a block are dropped at its end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < mdc_pkg::NCH; i++) begin
				wp[i] <= 2'h0;
				rp[i] <= 2'h0;
				fcnt[i] <= 3'h0;
			end
		end else if (st == mdc_pkg::ST_BEND) begin
			wp[act] <= 2'h0;
			rp[act] <= 2'h0;
			fcnt[act] <= 3'h0;
		end else if (rd_done) begin
			wp[act] <= wp[act] + 2'h1;
			fcnt[act] <= fcnt[act] + 3'h1;
		end else if (wr_done) begin
			rp[act] <= rp[act] + 2'h1;
			fcnt[act] <= fcnt[act] - 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rd_done) begin
			fifo_mem[act][wp[act]] <= mem_rdata;
		end
	end

	// channel registers: software writes, then hardware updates of the active channel
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < mdc_pkg::NCH; i++) begin
				{sar[i], dar[i], sar0[i], dar0[i]} <= '0;
				{channel_control_reg[i], ctl0[i], cfg[i], sgr[i], dsr[i]} <= '0;
				chain_pointer[i] <= 30'h0;
			end
		end else begin
			if (reg_wr && !reg_addr[7]) begin
				unique case (reg_addr[3:0])
					mdc_pkg::REG_SRC_ADDR: sar[reg_addr[6:4]] <= reg_wdata;
					mdc_pkg::REG_DST_ADDR: dar[reg_addr[6:4]] <= reg_wdata;
					mdc_pkg::REG_CHAIN:    chain_pointer[reg_addr[6:4]] <= reg_wdata[31:2];
					mdc_pkg::REG_CTL:      channel_control_reg[reg_addr[6:4]] <= reg_wdata;
					mdc_pkg::REG_CFG:      cfg[reg_addr[6:4]] <= reg_wdata;
					mdc_pkg::REG_GATHER:   sgr[reg_addr[6:4]] <= reg_wdata;
					mdc_pkg::REG_SCATTER:  dsr[reg_addr[6:4]] <= reg_wdata;
					default: begin
					end
				endcase
			end
			// snapshot at enable feeds auto-reload
			if (reg_wr && reg_addr == mdc_pkg::REG_CH_EN) begin
				for (int i = 0; i < mdc_pkg::NCH; i++) begin
					if (reg_wdata[i] && !ch_en[i]) begin
						sar0[i] <= sar[i];
						dar0[i] <= dar[i];
						ctl0[i] <= channel_control_reg[i];
					end
				end
			end
			if (rd_done) begin
				sar[act] <= adv(sar[act], cc.source_addr_step, cc.source_item_width, sbnd, sgr[act].step);
			end
			if (wr_done) begin
				dar[act] <= adv(dar[act], cc.dest_addr_step, cc.dest_item_width, dbnd, dsr[act].step);
			end
			if (fetch_ack) begin
				unique case (ccnt)
					2'h0: sar[act] <= mem_rdata[31:0];
					2'h1: dar[act] <= mem_rdata[31:0];
					2'h2: channel_control_reg[act] <= mem_rdata[31:0];
					2'h3: chain_pointer[act] <= mem_rdata[31:2];
				endcase
			end
			// contiguous sides keep their running address
			if (st == mdc_pkg::ST_BEND && !chained) begin
				if (cc.smb == mdc_pkg::MB_RELOAD) begin
					sar[act] <= sar0[act];
				end
				if (cc.dmb == mdc_pkg::MB_RELOAD) begin
					dar[act] <= dar0[act];
				end
				if (cc.smb == mdc_pkg::MB_RELOAD || cc.dmb == mdc_pkg::MB_RELOAD) begin
					channel_control_reg[act] <= ctl0[act];
				end
			end
		end
	end

	// global registers; event flags are set in preference to a clearing write
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{ch_en, sw_src, sw_dst, tfr_flag, blk_flag} <= '0;
		end else begin
			if (reg_wr && reg_addr == mdc_pkg::REG_CH_EN) begin
				ch_en <= reg_wdata[7:0];
			end
			if (fin) begin
				ch_en[act] <= 1'b0;
			end
			sw_src <= (sw_src & ~s_clr) | ((reg_wr && reg_addr == mdc_pkg::REG_SW_SRC) ? reg_wdata[23:0] : 24'h0);
			sw_dst <= (sw_dst & ~d_clr) | ((reg_wr && reg_addr == mdc_pkg::REG_SW_DST) ? reg_wdata[23:0] : 24'h0);
			tfr_flag <= (tfr_flag & ~((reg_wr && reg_addr == mdc_pkg::REG_DONE) ? reg_wdata[7:0] : 8'h0))
				| (fin ? 8'h1 << act : 8'h0);
			blk_flag <= (blk_flag & ~((reg_wr && reg_addr == mdc_pkg::REG_DONE) ? reg_wdata[15:8] : 8'h0))
				| ((st == mdc_pkg::ST_BEND) ? 8'h1 << act : 8'h0);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |{tfr_flag, blk_flag};
		end
	end

	// read data stands for exactly the cycle after the strobe
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= mdc_pkg::RST_WORD;
		end else if (!reg_rd) begin
			reg_rdata <= mdc_pkg::RST_WORD;
		end else if (!reg_addr[7]) begin
			unique case (reg_addr[3:0])
				mdc_pkg::REG_SRC_ADDR: reg_rdata <= sar[reg_addr[6:4]];
				mdc_pkg::REG_DST_ADDR: reg_rdata <= dar[reg_addr[6:4]];
				mdc_pkg::REG_CHAIN:    reg_rdata <= {chain_pointer[reg_addr[6:4]], 2'h0};
				mdc_pkg::REG_CTL:      reg_rdata <= channel_control_reg[reg_addr[6:4]];
				mdc_pkg::REG_CFG:      reg_rdata <= cfg[reg_addr[6:4]];
				mdc_pkg::REG_GATHER:   reg_rdata <= sgr[reg_addr[6:4]];
				mdc_pkg::REG_SCATTER:  reg_rdata <= dsr[reg_addr[6:4]];
				default:               reg_rdata <= mdc_pkg::RST_WORD;
			endcase
		end else begin
			unique case (reg_addr)
				mdc_pkg::REG_CH_EN:  reg_rdata <= {24'h0, ch_en};
				mdc_pkg::REG_SW_SRC: reg_rdata <= {8'h0, sw_src};
				mdc_pkg::REG_SW_DST: reg_rdata <= {8'h0, sw_dst};
				mdc_pkg::REG_DONE:   reg_rdata <= {16'h0, blk_flag, tfr_flag};
				mdc_pkg::REG_STATUS: reg_rdata <= {20'h0, cnt, st, act};
				default:             reg_rdata <= mdc_pkg::RST_WORD;
			endcase
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_fifo_depth_bound: assert property (fcnt[act] <= mdc_pkg::FFULL)
		else $error("fifo count above depth");
	a_fifo_mode_read: assert property ((st == mdc_pkg::ST_RD && $past(st) == mdc_pkg::ST_RUN && cf.fifo_mode)
		|-> $past(cnt) < mdc_pkg::FHALF)
		else $error("fifo mode read at half full");
	a_plain_write_data: assert property ((st == mdc_pkg::ST_WR && $past(st) == mdc_pkg::ST_RUN)
		|-> $past(cnt) != 3'h0)
		else $error("write launched from empty fifo");
	a_bus_req_hold: assert property ((mem_cmd.req && !mem_ack) |=> mem_cmd.req && $stable(mem_cmd.addr))
		else $error("bus request dropped before ack");
	a_periph_credit: assert property ((st == mdc_pkg::ST_RD && $past(st) == mdc_pkg::ST_RUN && cc.sper)
		|-> scred != 8'h0)
		else $error("peripheral read without request");
	a_sw_ignores_pins: assert property ((st == mdc_pkg::ST_RUN && cc.sper && cf.ssw && scred == 8'h0
		&& !swb && !sws) |=> scred == 8'h0)
		else $error("hardware request taken on software side");
	a_src_fixed_addr: assert property ((rd_done && cc.source_addr_step[1]) |=> $stable(cur_sar))
		else $error("fixed source address moved");
	a_src_inc_addr: assert property ((rd_done && cc.source_addr_step == mdc_pkg::STEP_INC && !sbnd)
		|=> cur_sar == $past(cur_sar) + (32'h1 << $past(cc.source_item_width)))
		else $error("source address step wrong");
	a_block_count: assert property ((st == mdc_pkg::ST_BEND && !pflow) |-> dcnt == cc.blk)
		else $error("block ended at wrong item count");
	a_irq_cause: assert property ($rose(irq) |-> $past(st, 2) == mdc_pkg::ST_BEND)
		else $error("interrupt without block end");
	a_chain_refetch: assert property ((st == mdc_pkg::ST_BEND && chained && chain_pointer[act] != 30'h0)
		|=> st == mdc_pkg::ST_FETCH)
		else $error("chain item not fetched at block start");
endmodule

// *** include/mdc_pkg.sv ***
// mdc_pkg: register map, field layouts, states and carriers of the multichannel dma controller
// assumes one 10 MHz clock and a word-indexed register port with 8-bit address
package mdc_pkg;
	localparam int         NCH          = 8;
	localparam int         NIF          = 16;
	localparam int         FDEPTH       = 4;
	localparam logic [2:0] FHALF        = 3'h2;
	localparam logic [2:0] FFULL        = 3'h4;
	localparam logic [3:0] REG_SRC_ADDR = 4'h0;
	localparam logic [3:0] REG_DST_ADDR = 4'h1;
	localparam logic [3:0] REG_CHAIN    = 4'h2;
	localparam logic [3:0] REG_CTL      = 4'h3;
	localparam logic [3:0] REG_CFG      = 4'h4;
	localparam logic [3:0] REG_GATHER   = 4'h5;
	localparam logic [3:0] REG_SCATTER  = 4'h6;
	localparam logic [7:0] REG_CH_EN    = 8'h80;
	localparam logic [7:0] REG_SW_SRC   = 8'h81;
	localparam logic [7:0] REG_SW_DST   = 8'h82;
	localparam logic [7:0] REG_DONE     = 8'h83;
	localparam logic [7:0] REG_STATUS   = 8'h84;
	localparam logic [1:0] STEP_INC     = 2'h0;
	localparam logic [1:0] STEP_DEC     = 2'h1;
	localparam logic [1:0] MB_RELOAD    = 2'h2;
	localparam logic [1:0] MB_CHAIN     = 2'h3;
	localparam logic [1:0] WORD_SIZE    = 2'h2;
	localparam logic [1:0] CHAIN_LAST   = 2'h3;
	localparam logic [1:0] REQ_GAP      = 2'h2;
	localparam logic [23:0] SW_CLR      = 24'h010101;
	localparam logic [31:0] RST_WORD    = 32'h0;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_FETCH = 6'h02,
		ST_RUN   = 6'h04,
		ST_RD    = 6'h08,
		ST_WR    = 6'h10,
		ST_BEND  = 6'h20
	} mdc_state_t;

	typedef struct packed {
		logic [11:0] blk;
		logic [1:0]  dmb;
		logic [1:0]  smb;
		logic        dper;
		logic        sper;
		logic [2:0]  dest_burst_length;
		logic [2:0]  source_burst_length;
		logic [1:0]  dest_addr_step;
		logic [1:0]  source_addr_step;
		logic [1:0]  dest_item_width;
		logic [1:0]  source_item_width;
	} mdc_ctl_t;

	typedef struct packed {
		logic [18:0] rsv;
		logic        pflow;
		logic        flow_prefetch_mode;
		logic        fifo_mode;
		logic        dsw;
		logic        ssw;
		logic [3:0]  dif;
		logic [3:0]  sif;
	} mdc_cfg_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic [19:0] step;
	} mdc_sg_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [63:0] wdata;
	} mdc_bus_t;
endpackage

// *** tb/mdc_mem_model.sv ***
// mdc_mem_model: system bus memory slave facing the engine's master port
// assumes one request at a time, held until acknowledged
`timescale 1ns/10ps
module mdc_mem_model (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  mdc_pkg::mdc_bus_t mem_cmd,
	output logic [63:0]       mem_rdata,
	output logic              mem_ack,
	output logic [31:0]       last_waddr,
	output logic [63:0]       last_wdata
);
	logic [1:0] wait_cnt;
	logic       slow;
	// memory answers each held request with a one-cycle ack, after alternately 0 or 3 wait cycles
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
			slow <= 1'b0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			slow <= ~slow;
			wait_cnt <= slow ? 2'h0 : 2'h3;
		end else if (mem_cmd.req && wait_cnt == 2'h0) begin
			mem_ack <= 1'b1;
		end else if (mem_cmd.req) begin
			wait_cnt <= wait_cnt - 2'h1;
		end
	end
	// data outside the ack cycle toggles so a stale sample cannot pass
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mem_rdata <= 64'h0;
			last_waddr <= 32'h0;
			last_wdata <= 64'h0;
		end else begin
			mem_rdata <= (mem_cmd.req && !mem_ack && wait_cnt == 2'h0) ? {~mem_cmd.addr, mem_cmd.addr} : ~mem_rdata;
			if (mem_ack && mem_cmd.we) begin
				last_waddr <= mem_cmd.addr;
				last_wdata <= mem_cmd.wdata;
			end
		end
	end
endmodule

// *** tb/multichannel_dma_controller_tb.sv ***
// multichannel_dma_controller_tb: register port, memory-to-memory and peripheral-to-memory checks
// assumes mdc_pkg compiled first and the memory model beside the engine
`timescale 1ns/10ps
module multichannel_dma_controller_tb;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, a, b, d;
	mdc_pkg::mdc_bus_t mem_cmd;
	mdc_pkg::mdc_ctl_t c;
	logic [63:0] mem_rdata, last_wdata;
	logic [31:0] last_waddr;
	logic mem_ack, irq;
	logic [15:0] per_ack;
	logic [15:0] per_req = 16'h0;
	logic [15:0] per_single = 16'h0;
	logic ack_seen;
	int errors = 0;
	int num_checks = 0;
	integer seed = 32'h88a68326;
	always #50 mclk = ~mclk;
	mdc_dma DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.per_req(per_req), .per_single(per_single), .per_last(16'h0), .per_ack(per_ack), .irq(irq));
	mdc_mem_model MEM (.mclk(mclk), .rst_b(rst_b), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.last_waddr(last_waddr), .last_wdata(last_wdata));
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= dt;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		dt = reg_rdata;
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		check("irq after reset", 64'h0, {63'h0, irq});
		check("req after reset", 64'h0, {63'h0, mem_cmd.req});
		for (int i = 0; i < 6; i++) begin
			a = $random(seed);
			b = {24'h0, 1'b0, 3'(i + 2), 4'h0};
			wr(b[7:0] | 8'(mdc_pkg::REG_SRC_ADDR), a);
			wr(b[7:0] | 8'(mdc_pkg::REG_CHAIN), a);
			rd(b[7:0] | 8'(mdc_pkg::REG_SRC_ADDR), d);
			check("source address", {32'h0, a}, {32'h0, d});
			rd(b[7:0] | 8'(mdc_pkg::REG_CHAIN), d);
			check("chain pointer", {32'h0, a & 32'hfffffffc}, {32'h0, d});
			@(negedge mclk);
			check("read data drops", 64'h0, {32'h0, reg_rdata});
		end
		rd(8'h90, d);
		check("unmapped read", 64'h0, {32'h0, d});
		for (int s = 0; s < 2; s++) begin
			a = $random(seed) & 32'h0fff_fff8 | 32'h1000_0000;
			b = $random(seed) & 32'h0fff_fff8 | 32'h1000_0000;
			c = '0;
			c.blk = 12'h2;
			c.source_item_width = 2'h3;
			c.dest_item_width = 2'h3;
			c.source_addr_step = 2'(s);
			c.dest_addr_step = 2'(s);
			wr(8'(mdc_pkg::REG_SRC_ADDR), a);
			wr(8'(mdc_pkg::REG_DST_ADDR), b);
			wr(8'(mdc_pkg::REG_CTL), c);
			wr(8'(mdc_pkg::REG_CFG), s ? 32'h400 : 32'h0);
			wr(mdc_pkg::REG_CH_EN, 32'h1);
			for (int t = 0; t < 300 && irq !== 1'b1; t++)
				@(negedge mclk);
			check("irq raised", 64'h1, {63'h0, irq});
			if (irq !== 1'b1)
				wrap_up();
			d = s ? a - 32'h8 : a + 32'h8;
			check("last write data", {~d, d}, last_wdata);
			d = s ? b - 32'h8 : b + 32'h8;
			check("last write addr", {32'h0, d}, {32'h0, last_waddr});
			rd(8'(mdc_pkg::REG_SRC_ADDR), d);
			check("source end", {32'h0, s ? a - 32'h10 : a + 32'h10}, {32'h0, d});
			wr(mdc_pkg::REG_CH_EN, 32'h0);
			wr(mdc_pkg::REG_DONE, 32'h0101);
			repeat (2) @(negedge mclk);
			check("irq cleared", 64'h0, {63'h0, irq});
		end
		for (int p = 0; p < 3; p++) begin
			a = $random(seed) & 32'h0fff_fff8 | 32'h2000_0000;
			b = $random(seed) & 32'h0fff_fff8 | 32'h3000_0000;
			c = '0;
			c.blk = (p == 2) ? 12'h1 : 12'h2;
			c.source_item_width = 2'h3;
			c.dest_item_width = 2'h3;
			c.source_addr_step = 2'h2;
			c.source_burst_length = 3'h1;
			c.sper = 1'b1;
			wr(8'(mdc_pkg::REG_SRC_ADDR), a);
			wr(8'(mdc_pkg::REG_DST_ADDR), b);
			wr(8'(mdc_pkg::REG_CTL), c);
			// source on request interface 3, software requests in the second pass
			wr(8'(mdc_pkg::REG_CFG), (p == 1) ? 32'h103 : 32'h3);
			wr(mdc_pkg::REG_CH_EN, 32'h1);
			repeat (8) @(negedge mclk);
			check("access without request", 64'h0, {63'h0, mem_cmd.req});
			@(posedge mclk);
			per_req <= (p == 2) ? 16'h0 : 16'h8;
			per_single <= (p == 2) ? 16'h8 : 16'h0;
			if (p == 1) begin
				repeat (8) @(negedge mclk);
				check("pins on software side", 64'h0, {63'h0, mem_cmd.req});
				wr(mdc_pkg::REG_SW_SRC, 32'h1);
			end
			ack_seen = 1'b0;
			for (int t = 0; t < 300 && irq !== 1'b1; t++) begin
				@(negedge mclk);
				if (per_ack[3] === 1'b1) begin
					ack_seen = 1'b1;
					@(posedge mclk);
					per_req <= 16'h0;
					per_single <= 16'h0;
				end
			end
			check("periph irq", 64'h1, {63'h0, irq});
			if (irq !== 1'b1)
				wrap_up();
			check("request ack", {63'h0, p != 1}, {63'h0, ack_seen});
			d = (p == 2) ? b : b + 32'h8;
			check("periph write addr", {32'h0, d}, {32'h0, last_waddr});
			check("periph write data", {~a, a}, last_wdata);
			@(posedge mclk);
			per_req <= 16'h0;
			per_single <= 16'h0;
			rd(mdc_pkg::REG_SW_SRC, d);
			check("software request taken", 64'h0, {32'h0, d});
			rd(8'(mdc_pkg::REG_SRC_ADDR), d);
			check("fixed source", {32'h0, a}, {32'h0, d});
			wr(mdc_pkg::REG_CH_EN, 32'h0);
			wr(mdc_pkg::REG_DONE, 32'h0101);
			repeat (2) @(negedge mclk);
			check("periph irq cleared", 64'h0, {63'h0, irq});
		end
		wrap_up();
	end
endmodule
